// ---- logic/caw_pkg.sv ----
// Constants shared by the counter array watchdog design.
//
// Overview of operation
// [R1] Reset when low byte overflows at high match.
// [R2] Writing one to last flag forces reset.
// [R3] Software configures before enabling, then updates.
// [R4] Timebase and idle bits frozen while enabled.
// [R5] Enabled when enable bit or lock set.
// [R6] Lock holds enable until reset; else clearable.
// [R7] Reset: enabled, system_clock/12, low and offset zero.
// [R8] Overflow flag set on 16-bit wrap, sticky.
// [R9] Overflow flag requests interrupt when enabled.
// [R10] Run bit stops or starts the counter.
// [R11] Six module flags set by hardware, sticky; hardware does not set flag 5 while the watchdog is enabled.
// [R12] Idle suspend bit halts array in idle.
// [R13] Timebase select chooses one of seven sources.
// [R14] External count input limited to quarter rate.
// [R15] Enable bit set blocks other mode bit writes.
// [R16] Mode bit four reads zero, ignores writes.
// [R17] Update write loads high byte plus offset.
// [R18] Enabled watchdog forces run, blocks counter writes.
// [R19] Run bit reads software value, cannot stop.
// [R20] Timeout is 256 times offset plus remainder.
// [R21] Watchdog reset leaves as one-cycle pulse.
package caw_pkg;
    localparam logic [7:0] CAW_ADDR_CONTROL = 8'hd8;
    localparam logic [7:0] CAW_ADDR_MODE    = 8'hd9;
    localparam logic [7:0] CAW_ADDR_LOW     = 8'he9;
    localparam logic [7:0] CAW_ADDR_HIGH    = 8'hf9;
    localparam logic [7:0] CAW_ADDR_OFFSET  = 8'hd2;
    localparam logic [7:0] CAW_ADDR_UPDATE  = 8'hd3;

    localparam int CTL_CF   = 7;
    localparam int CTL_CR   = 6;
    localparam int CTL_LAST = 5;

    localparam int MD_IDLE_SUSPEND_BIT   = 7;
    localparam int MD_WATCHDOG_ENABLE_BIT   = 6;
    localparam int MD_WATCHDOG_LOCK_BIT  = 5;
    localparam int MD_CPS_HI = 3;
    localparam int MD_CPS_LO = 1;
    localparam int MD_ECF    = 0;

    localparam int         CAW_FLAG_COUNT = 6;
    localparam logic [7:0] CAW_BYTE_MAX   = 8'hff;
    localparam logic [7:0] CAW_BYTE_ZERO  = 8'h00;

    localparam logic [2:0] CPS_DIV12  = 3'h0;
    localparam logic [2:0] CPS_DIV4   = 3'h1;
    localparam logic [2:0] CPS_TIMER0 = 3'h2;
    localparam logic [2:0] CPS_ECI    = 3'h3;
    localparam logic [2:0] CPS_SYSTEM_CLOCK = 3'h4;
    localparam logic [2:0] CPS_EXTCLK = 3'h5;
    localparam logic [2:0] CPS_RTC    = 3'h6;

    localparam logic [3:0] CAW_DIV12_LAST = 4'hb;
    localparam logic [3:0] CAW_DIV4_LAST  = 4'h3;
    localparam logic [2:0] CAW_DIV8_LAST  = 3'h7;
    localparam int         CAW_ECI_MIN_GAP = 4;

    localparam logic       CAW_RST_WATCHDOG_ENABLE_BIT = 1'b1;
    localparam logic [2:0] CAW_RST_CPS  = CPS_DIV12;
endpackage : caw_pkg

// ---- logic/caw_timebase.sv ----
// Timebase selector that turns the chosen source into count ticks.
`timescale 1ns/1ns
`default_nettype none
module caw_timebase #(
    parameter int ECI_MIN_GAP = caw_pkg::CAW_ECI_MIN_GAP
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [2:0] sel,
    input  wire logic       active,
    input  wire logic       timer0Ovf,
    input  wire logic [2:0] pinsIn,
    output var  logic       tick
);
    import caw_pkg::*;

    generate
        if (ECI_MIN_GAP < 1 || ECI_MIN_GAP > 15) begin : g_chk
            $error("ECI_MIN_GAP must lie between 1 and 15.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] syncA_ff;
    logic [2:0] syncB_ff;
    logic [2:0] syncC_ff;
    logic [2:0] fallEdge;
    logic [2:0] riseEdge;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    syncA_ff[gi] <= 1'b0;
                    syncB_ff[gi] <= 1'b0;
                    syncC_ff[gi] <= 1'b0;
                end else begin
                    syncA_ff[gi] <= pinsIn[gi];
                    syncB_ff[gi] <= syncA_ff[gi];
                    syncC_ff[gi] <= syncB_ff[gi];
                end
            end
            assign fallEdge[gi] = syncC_ff[gi] & ~syncB_ff[gi];
            assign riseEdge[gi] = ~syncC_ff[gi] & syncB_ff[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] divCnt_ff;
    logic [3:0] nxt_divCnt;
    logic [3:0] gapCnt_ff;
    logic [3:0] nxt_gapCnt;
    logic [2:0] extCnt_ff;
    logic [2:0] nxt_extCnt;
    logic [2:0] rtcCnt_ff;
    logic [2:0] nxt_rtcCnt;
    logic       tick_ff;
    logic       nxt_tick;
    logic [3:0] divLast;

    always_comb begin
        divLast    = (sel == CPS_DIV4) ? CAW_DIV4_LAST : CAW_DIV12_LAST;
        nxt_divCnt = divCnt_ff;
        nxt_gapCnt = gapCnt_ff;
        nxt_extCnt = extCnt_ff;
        nxt_rtcCnt = rtcCnt_ff;
        nxt_tick   = 1'b0;
        // Edges inside the gap are dropped so ticks never exceed a quarter rate.
        if (gapCnt_ff < 4'(ECI_MIN_GAP - 1)) begin
            nxt_gapCnt = gapCnt_ff + 4'h1; // R14
        end
        if (active) begin
            case (sel) // R13
                CPS_DIV12, CPS_DIV4: begin
                    nxt_divCnt = (divCnt_ff >= divLast) ? 4'h0 : divCnt_ff + 4'h1;
                    nxt_tick   = (divCnt_ff >= divLast);
                end
                CPS_TIMER0: nxt_tick = timer0Ovf;
                CPS_ECI: begin
                    if (fallEdge[0] && gapCnt_ff >= 4'(ECI_MIN_GAP - 1)) begin
                        nxt_tick   = 1'b1; // R14
                        nxt_gapCnt = 4'h0;
                    end
                end
                CPS_SYSTEM_CLOCK: nxt_tick = 1'b1;
                CPS_EXTCLK: begin
                    if (riseEdge[1]) begin
                        nxt_extCnt = extCnt_ff + 3'h1;
                        nxt_tick   = (extCnt_ff == CAW_DIV8_LAST);
                    end
                end
                CPS_RTC: begin
                    if (riseEdge[2]) begin
                        nxt_rtcCnt = rtcCnt_ff + 3'h1;
                        nxt_tick   = (rtcCnt_ff == CAW_DIV8_LAST);
                    end
                end
                default: nxt_tick = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCnt_ff <= 4'h0;
            gapCnt_ff <= 4'h0;
            extCnt_ff <= 3'h0;
            rtcCnt_ff <= 3'h0;
            tick_ff   <= 1'b0;
        end else begin
            divCnt_ff <= nxt_divCnt;
            gapCnt_ff <= nxt_gapCnt;
            extCnt_ff <= nxt_extCnt;
            rtcCnt_ff <= nxt_rtcCnt;
            tick_ff   <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule : caw_timebase
`default_nettype wire

// ---- logic/caw_watchdog.sv ----
// Counter array core with its watchdog, control and mode registers.
`timescale 1ns/1ns
`default_nettype none
module caw_watchdog (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic [7:0]                        sfrAddr,
    input  wire logic                              sfrWr,
    input  wire logic [7:0]                        sfrWrData,
    output var  logic [7:0]                        sfrRdData,
    input  wire logic                              cpuIdle,
    input  wire logic                              timer0Ovf,
    input  wire logic                              extCountIn,
    input  wire logic                              extClkIn,
    input  wire logic                              rtcClkIn,
    input  wire logic [caw_pkg::CAW_FLAG_COUNT-1:0] moduleMatch,
    input  wire logic [caw_pkg::CAW_FLAG_COUNT-1:0] moduleIrqEn,
    output var  logic                              irqReq,
    output var  logic                              wdogEnabled,
    output var  logic                              wdogResetPulse
);
    import caw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]                low_ff;
    logic [7:0]                nxt_low;

    logic [7:0]                high_ff;
    logic [7:0]                nxt_high;

    logic [7:0]                offset_ff;
    logic [7:0]                nxt_offset;

    logic [7:0]                update_ff;
    logic [7:0]                nxt_update;

    logic                      ovfFlag_ff;
    logic                      nxt_ovfFlag;

    logic                      run_ff;
    logic                      nxt_run;

    logic [CAW_FLAG_COUNT-1:0] flags_ff;
    logic [CAW_FLAG_COUNT-1:0] nxt_flags;

    logic                      idleSuspend_ff;
    logic                      nxt_idleSuspend;

    logic                      watchdog_enable_bit_ff;
    logic                      nxt_watchdog_enable_bit;

    logic                      lock_ff;
    logic                      nxt_lock;

    logic [2:0]                cps_ff;
    logic [2:0]                nxt_cps;

    logic                      ecf_ff;
    logic                      nxt_ecf;

    logic                      rstPulse_ff;
    logic                      nxt_rstPulse;

    logic [7:0]                rdData_ff;
    logic [7:0]                nxt_rdData;

    logic wdEn;
    logic suspended;
    logic tick;
    logic step;
    logic lowWrap;
    logic fullWrap;
    logic wrCtl;
    logic wrMode;
    logic [CAW_FLAG_COUNT-1:0] flagSet;

    assign wdEn      = watchdog_enable_bit_ff | lock_ff; // R5
    assign suspended = idleSuspend_ff & cpuIdle; // R12
    // The watchdog overrides the run bit so software cannot stall it.
    assign step      = tick & (run_ff | wdEn) & ~suspended; // R10 R18
    assign lowWrap   = step && (low_ff == CAW_BYTE_MAX);
    assign fullWrap  = lowWrap && (high_ff == CAW_BYTE_MAX);
    assign wrCtl     = sfrWr && (sfrAddr == CAW_ADDR_CONTROL);
    assign wrMode    = sfrWr && (sfrAddr == CAW_ADDR_MODE);

    caw_timebase u_timebase (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .sel       (cps_ff),
        .active    (~suspended),
        .timer0Ovf (timer0Ovf),
        .pinsIn    ({rtcClkIn, extClkIn, extCountIn}),
        .tick      (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_low    = low_ff;
        nxt_high   = high_ff;
        nxt_offset = offset_ff;
        nxt_update = update_ff;
        if (step) begin
            nxt_low = low_ff + 8'h01;
            if (lowWrap) begin
                nxt_high = high_ff + 8'h01;
            end
        end
        if (sfrWr && !wdEn && sfrAddr == CAW_ADDR_LOW) begin
            nxt_low = sfrWrData; // R18
        end
        if (sfrWr && !wdEn && sfrAddr == CAW_ADDR_HIGH) begin
            nxt_high = sfrWrData; // R18
        end
        if (sfrWr && sfrAddr == CAW_ADDR_OFFSET) begin
            nxt_offset = sfrWrData;
        end
        // Loading offset_ff periods past the high byte gives the remainder of the low byte on top.
        if (sfrWr && sfrAddr == CAW_ADDR_UPDATE) begin
            nxt_update = high_ff + offset_ff; // R17 R20
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_ff    <= CAW_BYTE_ZERO; // R7
            high_ff   <= CAW_BYTE_ZERO;
            offset_ff <= CAW_BYTE_ZERO; // R7
            update_ff <= CAW_BYTE_ZERO;
        end else begin
            low_ff    <= nxt_low;
            high_ff   <= nxt_high;
            offset_ff <= nxt_offset;
            update_ff <= nxt_update;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        flagSet = moduleMatch;
        if (wdEn) begin
            flagSet[CTL_LAST] = 1'b0;
        end
        nxt_ovfFlag = ovfFlag_ff;
        nxt_run     = run_ff;
        nxt_flags   = flags_ff;
        if (wrCtl) begin
            nxt_ovfFlag = sfrWrData[CTL_CF];
            nxt_run     = sfrWrData[CTL_CR]; // R19
            nxt_flags   = sfrWrData[CAW_FLAG_COUNT-1:0];
        end
        // Hardware set wins over a software clear in the same cycle.
        nxt_ovfFlag = nxt_ovfFlag | fullWrap; // R8
        nxt_flags   = nxt_flags | flagSet; // R11
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovfFlag_ff <= 1'b0;
            run_ff     <= 1'b0;
            flags_ff   <= '0;
        end else begin
            ovfFlag_ff <= nxt_ovfFlag;
            run_ff     <= nxt_run;
            flags_ff   <= nxt_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_idleSuspend = idleSuspend_ff;
        nxt_watchdog_enable_bit        = watchdog_enable_bit_ff;
        nxt_lock        = lock_ff;
        nxt_cps         = cps_ff;
        nxt_ecf         = ecf_ff;
        if (wrMode) begin
            nxt_watchdog_enable_bit = sfrWrData[MD_WATCHDOG_ENABLE_BIT]; // R6
            if (!watchdog_enable_bit_ff) begin // R15
                nxt_lock = lock_ff | sfrWrData[MD_WATCHDOG_LOCK_BIT]; // R6
                nxt_ecf  = sfrWrData[MD_ECF];
                if (!wdEn) begin // R4
                    nxt_idleSuspend = sfrWrData[MD_IDLE_SUSPEND_BIT];
                    nxt_cps         = sfrWrData[MD_CPS_HI:MD_CPS_LO];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idleSuspend_ff <= 1'b0;
            watchdog_enable_bit_ff        <= CAW_RST_WATCHDOG_ENABLE_BIT; // R7
            lock_ff        <= 1'b0;
            cps_ff         <= CAW_RST_CPS; // R7
            ecf_ff         <= 1'b0;
        end else begin
            idleSuspend_ff <= nxt_idleSuspend;
            watchdog_enable_bit_ff        <= nxt_watchdog_enable_bit;
            lock_ff        <= nxt_lock;
            cps_ff         <= nxt_cps;
            ecf_ff         <= nxt_ecf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_rstPulse = 1'b0;
        if (wdEn && lowWrap && high_ff == update_ff) begin
            nxt_rstPulse = 1'b1; // R1
        end
        if (wdEn && wrCtl && sfrWrData[CTL_LAST]) begin
            nxt_rstPulse = 1'b1; // R2
        end
        case (sfrAddr)
            CAW_ADDR_CONTROL: nxt_rdData = {ovfFlag_ff, run_ff, flags_ff}; // R19
            CAW_ADDR_MODE: nxt_rdData = {idleSuspend_ff, watchdog_enable_bit_ff, lock_ff, 1'b0,
                                         cps_ff, ecf_ff}; // R16
            CAW_ADDR_LOW: nxt_rdData = low_ff;
            CAW_ADDR_HIGH: nxt_rdData = high_ff;
            CAW_ADDR_OFFSET: nxt_rdData = offset_ff;
            CAW_ADDR_UPDATE: nxt_rdData = update_ff;
            default: nxt_rdData = 8'h00;
        endcase
    end

    // The pulse clears itself; the system reset logic then resets this block.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rstPulse_ff <= 1'b0;
            rdData_ff   <= 8'h00;
        end else begin
            rstPulse_ff <= nxt_rstPulse; // R21
            rdData_ff   <= nxt_rdData;
        end
    end

    assign sfrRdData      = rdData_ff;
    assign wdogResetPulse = rstPulse_ff;
    assign wdogEnabled    = wdEn;
    assign irqReq         = (ovfFlag_ff & ecf_ff) | (|(flags_ff & moduleIrqEn)); // R9 R11

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wdog_timeout_a: assert property ( // R1
        (wdEn && step && low_ff == 8'hff && high_ff == update_ff) |=> wdogResetPulse)
        else $error("Watchdog match at low byte overflow gave no reset.");

    soft_force_a: assert property ( // R2
        (wdEn && wrCtl && sfrWrData[5]) |=> wdogResetPulse)
        else $error("Forced watchdog reset did not occur.");

    // A second pulse is only legal when a fresh cause stood in the pulse cycle.
    pulse_single_a: assert property ( // R21
        wdogResetPulse |=> !wdogResetPulse || $past(wrCtl || lowWrap))
        else $error("Watchdog reset pulse stood for more than one cycle.");

    frozen_cfg_a: assert property ( // R4
        wdEn |=> $stable(cps_ff) && $stable(idleSuspend_ff))
        else $error("Timebase or idle bit changed while enabled.");

    lock_hold_a: assert property ( // R6
        lock_ff |=> lock_ff && wdogEnabled)
        else $error("Lock released before reset.");

    wrap_flag_a: assert property ( // R8
        (step && low_ff == 8'hff && high_ff == 8'hff) |=> ovfFlag_ff)
        else $error("Counter wrap did not set the overflow flag.");

    ovf_irq_a: assert property ( // R9
        (ovfFlag_ff && ecf_ff) |-> irqReq)
        else $error("Overflow flag with enable raised no request.");

    stop_hold_a: assert property ( // R10
        (!run_ff && !wdEn && !sfrWr) |=> $stable(low_ff) && $stable(high_ff))
        else $error("Stopped counter moved.");

    idle_hold_a: assert property ( // R12
        (suspended && !sfrWr) |=> $stable(low_ff) && $stable(high_ff))
        else $error("Counter moved while suspended in idle.");

    // Only a carry from the low byte may move the high byte while enabled.
    counter_guard_a: assert property ( // R18
        (wdEn && sfrWr && sfrAddr == CAW_ADDR_HIGH && !lowWrap) |=> $stable(high_ff))
        else $error("Counter high byte written while watchdog enabled.");

    mode_bit4_a: assert property ( // R16
        (sfrAddr == 8'hd9) |=> sfrRdData[4] == 1'b0)
        else $error("Unused mode bit read as one.");

    update_load_a: assert property ( // R17
        (sfrWr && sfrAddr == 8'hd3) |=> update_ff == 8'($past(high_ff) + $past(offset_ff)))
        else $error("Update register not loaded with high byte plus offset.");

    mode_lock_a: assert property ( // R15
        (watchdog_enable_bit_ff && wrMode) |=> $stable(ecf_ff) && $stable(lock_ff))
        else $error("Mode bit changed while enable bit set.");
endmodule : caw_watchdog
`default_nettype wire

// ---- verification/caw_testbench.sv ----
// Self-checking testbench for the counter array watchdog.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import caw_pkg::*;
    logic                      clk_sys     = 1'b0;
    logic                      rst         = 1'b1;
    logic [7:0]                sfrAddr     = 8'h00;
    logic                      sfrWr       = 1'b0;
    logic [7:0]                sfrWrData   = 8'h00;
    logic [7:0]                sfrRdData;
    logic                      cpuIdle     = 1'b0;
    logic                      timer0Ovf   = 1'b0;
    logic                      extCountIn  = 1'b1;
    logic                      extClkIn    = 1'b0;
    logic                      rtcClkIn    = 1'b0;
    logic [CAW_FLAG_COUNT-1:0] moduleMatch = 6'h00;
    logic [CAW_FLAG_COUNT-1:0] moduleIrqEn = 6'h00;
    logic                      irqReq;
    logic                      wdogEnabled;
    logic                      wdogResetPulse;
    int                        n_errors    = 0;
    int                        n_compared  = 0;
    int                        cyc         = 0;
    int                        nPulse      = 0;
    int                        pulseCyc    = 0;

    always #25 clk_sys = ~clk_sys;

    caw_watchdog DUT (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .sfrAddr        (sfrAddr),
        .sfrWr          (sfrWr),
        .sfrWrData      (sfrWrData),
        .sfrRdData      (sfrRdData),
        .cpuIdle        (cpuIdle),
        .timer0Ovf      (timer0Ovf),
        .extCountIn     (extCountIn),
        .extClkIn       (extClkIn),
        .rtcClkIn       (rtcClkIn),
        .moduleMatch    (moduleMatch),
        .moduleIrqEn    (moduleIrqEn),
        .irqReq         (irqReq),
        .wdogEnabled    (wdogEnabled),
        .wdogResetPulse (wdogResetPulse)
    );

    // Counting high cycles also proves the reset request is one cycle wide.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (wdogResetPulse === 1'b1) begin
            nPulse   <= nPulse + 1;
            pulseCyc <= cyc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic inRange(input string what, input logic [15:0] v, input int lo, input int hi);
        check(what, (v >= lo && v <= hi) ? 8'h01 : 8'h00, 8'h01);
    endtask : inRange

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #2;
        sfrAddr   = a;
        sfrWrData = d;
        sfrWr     = 1'b1;
        @(posedge clk_sys);
        #2;
        sfrWr = 1'b0;
    endtask : wr

    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #2;
        sfrAddr = a;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        d = sfrRdData;
    endtask : rdReg

    task automatic expectReg(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rdReg(a, v);
        check(what, v, exp);
    endtask : expectReg

    task automatic doReset();
        @(posedge clk_sys);
        #2;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2;
        rst = 1'b0;
    endtask : doReset

    // Bounded wait for the next reset request; running out ends the run.
    task automatic waitPulse(input int limit);
        int p0;
        int n;
        p0 = nPulse;
        n  = 0;
        while (nPulse == p0 && n < limit) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (nPulse == p0) begin
            n_errors++;
            $display("CHECK FAILED watchdog reset expected 1 seen 0");
            summarize();
        end
    endtask : waitPulse

    // Counts ticks over a fixed span; every pin source is toggled, but timer0Ovf pulses only when timer 0 is the chosen source.
    task automatic measure(input logic [2:0] code, input logic fast, input int lo, input int hi);
        logic [7:0] v;
        wr(CAW_ADDR_MODE, {4'h0, code, 1'b0});
        wr(CAW_ADDR_CONTROL, 8'h40);
        wr(CAW_ADDR_LOW, 8'h00);
        for (int i = 0; i < 48; i++) begin
            @(posedge clk_sys);
            #2;
            timer0Ovf  = (code == CPS_TIMER0) && (i % 8 == 0);
            extCountIn = fast ? i[0] : i[2];
            extClkIn   = i[0];
            rtcClkIn   = i[0];
        end
        @(posedge clk_sys);
        #2;
        timer0Ovf = 1'b0;
        repeat (6) @(posedge clk_sys);
        wr(CAW_ADDR_CONTROL, 8'h00);
        rdReg(CAW_ADDR_LOW, v);
        inRange("timebase count", {8'h00, v}, lo, hi);
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        logic [7:0] v2;
        int         t0;
        int         p0;
        repeat (2) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        t0  = cyc;
        check("enabled after reset", {7'h00, wdogEnabled}, 8'h01);
        expectReg("control reset", CAW_ADDR_CONTROL, 8'h00);
        expectReg("mode reset", CAW_ADDR_MODE, 8'h40);
        expectReg("offset reset", CAW_ADDR_OFFSET, 8'h00);
        waitPulse(4000);
        inRange("default timeout", 16'(pulseCyc - t0), 3066, 3082);
        repeat (3) @(posedge clk_sys);
        check("pulse width", 8'(nPulse), 8'h01);
        doReset();
        wr(CAW_ADDR_MODE, 8'h10);
        check("disabled", {7'h00, wdogEnabled}, 8'h00);
        expectReg("mode unused bit", CAW_ADDR_MODE, 8'h00);
        wr(CAW_ADDR_LOW, 8'h55);
        wr(CAW_ADDR_HIGH, 8'haa);
        expectReg("stopped low", CAW_ADDR_LOW, 8'h55);
        expectReg("stopped high", CAW_ADDR_HIGH, 8'haa);
        measure(CPS_DIV12, 1'b0, 4, 5);
        measure(CPS_DIV4, 1'b0, 13, 16);
        measure(CPS_TIMER0, 1'b0, 6, 6);
        measure(CPS_ECI, 1'b0, 5, 6);
        measure(CPS_ECI, 1'b1, 6, 13);
        measure(CPS_SYSTEM_CLOCK, 1'b0, 55, 59);
        measure(CPS_EXTCLK, 1'b0, 2, 3);
        measure(CPS_RTC, 1'b0, 2, 3);
        measure(3'h7, 1'b0, 0, 0);
        wr(CAW_ADDR_MODE, 8'h09);
        wr(CAW_ADDR_HIGH, 8'hff);
        wr(CAW_ADDR_LOW, 8'hf0);
        wr(CAW_ADDR_CONTROL, 8'h40);
        repeat (40) @(posedge clk_sys);
        expectReg("overflow flag sticky", CAW_ADDR_CONTROL, 8'hc0);
        check("overflow irq", {7'h00, irqReq}, 8'h01);
        wr(CAW_ADDR_CONTROL, 8'h00);
        check("overflow irq cleared", {7'h00, irqReq}, 8'h00);
        wr(CAW_ADDR_MODE, 8'h08);
        wr(CAW_ADDR_CONTROL, 8'h80);
        check("overflow irq masked", {7'h00, irqReq}, 8'h00);
        wr(CAW_ADDR_CONTROL, 8'h00);
        for (int i = 0; i < CAW_FLAG_COUNT; i++) begin
            @(posedge clk_sys);
            #2;
            moduleIrqEn    = 6'h00;
            moduleMatch[i] = 1'b1;
            @(posedge clk_sys);
            #2;
            moduleMatch = 6'h00;
            expectReg("module flag", CAW_ADDR_CONTROL, 8'h01 << i);
            check("flag irq masked", {7'h00, irqReq}, 8'h00);
            moduleIrqEn[i] = 1'b1;
            #1;
            check("flag irq", {7'h00, irqReq}, 8'h01);
            wr(CAW_ADDR_CONTROL, 8'h00);
            check("flag cleared", {7'h00, irqReq}, 8'h00);
        end
        wr(CAW_ADDR_MODE, 8'h88);
        wr(CAW_ADDR_CONTROL, 8'h40);
        cpuIdle = 1'b1;
        rdReg(CAW_ADDR_LOW, v);
        rdReg(CAW_ADDR_LOW, v2);
        check("idle suspended", v2, v);
        cpuIdle = 1'b0;
        rdReg(CAW_ADDR_LOW, v2);
        check("idle resumed", (v2 != v) ? 8'h01 : 8'h00, 8'h01);
        wr(CAW_ADDR_MODE, 8'h08);
        wr(CAW_ADDR_OFFSET, 8'hff);
        wr(CAW_ADDR_MODE, 8'h48);
        wr(CAW_ADDR_UPDATE, 8'h00);
        check("enabled by bit", {7'h00, wdogEnabled}, 8'h01);
        wr(CAW_ADDR_MODE, 8'hc3);
        expectReg("mode frozen", CAW_ADDR_MODE, 8'h48);
        wr(CAW_ADDR_CONTROL, 8'h00);
        expectReg("run bit reads zero", CAW_ADDR_CONTROL, 8'h00);
        rdReg(CAW_ADDR_LOW, v);
        rdReg(CAW_ADDR_LOW, v2);
        check("forced run", (v2 != v) ? 8'h01 : 8'h00, 8'h01);
        rdReg(CAW_ADDR_HIGH, v);
        wr(CAW_ADDR_HIGH, v ^ 8'h80);
        rdReg(CAW_ADDR_HIGH, v2);
        inRange("high write blocked", {8'h00, 8'(v2 - v)}, 0, 1);
        p0 = nPulse;
        wr(CAW_ADDR_CONTROL, 8'h20);
        repeat (2) @(posedge clk_sys);
        check("forced reset", 8'(nPulse - p0), 8'h01);
        doReset();
        wr(CAW_ADDR_MODE, 8'h00);
        p0 = nPulse;
        wr(CAW_ADDR_CONTROL, 8'h20);
        repeat (2) @(posedge clk_sys);
        check("no forced reset", 8'(nPulse - p0), 8'h00);
        expectReg("flag set instead", CAW_ADDR_CONTROL, 8'h20);
        wr(CAW_ADDR_MODE, 8'h20);
        check("enabled by lock", {7'h00, wdogEnabled}, 8'h01);
        wr(CAW_ADDR_MODE, 8'h00);
        check("lock holds", {7'h00, wdogEnabled}, 8'h01);
        expectReg("lock kept", CAW_ADDR_MODE, 8'h20);
        doReset();
        wr(CAW_ADDR_MODE, 8'h08);
        wr(CAW_ADDR_OFFSET, 8'h01);
        wr(CAW_ADDR_LOW, 8'h00);
        wr(CAW_ADDR_HIGH, 8'h00);
        wr(CAW_ADDR_MODE, 8'h48);
        wr(CAW_ADDR_UPDATE, 8'h5a);
        t0 = cyc;
        expectReg("update load", CAW_ADDR_UPDATE, 8'h01);
        waitPulse(700);
        inRange("offset timeout", 16'(pulseCyc - t0), 500, 516);
        summarize();
    end
endmodule : testbench
`default_nettype wire
